// ==== core/pamc_pkg.sv ====
// constants for the pulse accumulator and modulus down-counter block
package pamc_pkg;
	// register byte addresses
	localparam logic [7:0] PAMC_ADR_ACTL   = 8'hA0;
	localparam logic [7:0] PAMC_ADR_AFLG   = 8'hA1;
	localparam logic [7:0] PAMC_ADR_CNT3   = 8'hA2;
	localparam logic [7:0] PAMC_ADR_CNT2   = 8'hA3;
	localparam logic [7:0] PAMC_ADR_CNT1   = 8'hA4;
	localparam logic [7:0] PAMC_ADR_CNT0   = 8'hA5;
	localparam logic [7:0] PAMC_ADR_MCTL   = 8'hA6;
	localparam logic [7:0] PAMC_ADR_MFLG   = 8'hA7;
	localparam logic [7:0] PAMC_ADR_BCEN   = 8'hA8;
	localparam logic [7:0] PAMC_ADR_CSYS   = 8'hAB;
	localparam logic [7:0] PAMC_ADR_TSYS   = 8'h86;
	localparam logic [7:0] PAMC_ADR_BCTL   = 8'hB0;
	localparam logic [7:0] PAMC_ADR_BFLG   = 8'hB1;
	localparam logic [7:0] PAMC_ADR_MCNTH  = 8'hB6;
	localparam logic [7:0] PAMC_ADR_MCNTL  = 8'hB7;
	// accum_a_control fields
	localparam int PAMC_A_EN   = 6;
	localparam int PAMC_A_MOD  = 5;
	localparam int PAMC_A_EDGE = 4;
	localparam int PAMC_A_CKH  = 3;
	localparam int PAMC_A_CKL  = 2;
	localparam int PAMC_A_OVI  = 1;
	localparam int PAMC_A_II   = 0;
	localparam logic [7:0] PAMC_ACTL_MASK = 8'h7F;
	// flag positions in the accumulator A flag register; the B flag register has only the overflow bit
	localparam int PAMC_F_OV = 1;
	localparam int PAMC_F_IE = 0;
	// downcounter_control fields
	localparam int PAMC_M_ZI   = 7;
	localparam int PAMC_M_MOD  = 6;
	localparam int PAMC_M_RDL  = 5;
	localparam int PAMC_M_LAT  = 4;
	localparam int PAMC_M_FLD  = 3;
	localparam int PAMC_M_EN   = 2;
	localparam logic [7:0] PAMC_MCTL_MASK = 8'hE7;
	localparam int PAMC_M_ZF   = 7;
	// timer system control, capture system, accumulator B control
	localparam int PAMC_T_EN   = 7;
	localparam int PAMC_T_FFC  = 4;
	localparam int PAMC_C_BUF  = 1;
	localparam int PAMC_C_LATCH_OR_QUEUE_SELECT = 0;
	localparam int PAMC_B_EN   = 6;
	// reset values and presets
	localparam logic [7:0]  PAMC_RST_BYTE = 8'h00;
	localparam logic [15:0] PAMC_MC_PRESET = 16'hFFFF;
	// clock select codes
	localparam logic [1:0] PAMC_CK_PRESC = 2'h0;
	localparam logic [1:0] PAMC_CK_ACC   = 2'h1;
	localparam logic [1:0] PAMC_CK_D256  = 2'h2;
	localparam logic [1:0] PAMC_CK_D64K  = 2'h3;
endpackage

// ==== core/pamc_core.sv ====
// pulse accumulators A and B with the modulus down-counter
`timescale 1ns/1ns
`default_nettype none
module pamc_core
	import pamc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  bus_addr,
	input  wire logic [15:0] bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic        bus_word,
	output logic      [15:0] bus_rdata,
	input  wire logic        timer_pin_7,
	input  wire logic        timer_presc_tick,
	input  wire logic        timer_div64_tick,
	input  wire logic [3:0]  chan_count_evt,
	input  wire logic [3:0]  chan_capture,
	input  wire logic [3:0]  chan_capture_rising,
	output logic             timer_count_tick,
	output logic             capture_latch,
	output logic      [31:0] hold_accum,
	output logic             accum_a_irq,
	output logic             downcounter_irq
);

	typedef struct packed {
		logic [7:0]       actl;
		logic [1:0]       aflg;
		logic [3:0][7:0]  cnt;
		logic [3:0]       bcen;
		logic [7:0]       tsys;
		logic [1:0]       csys;
		logic             accum_b_system_enable;
		logic             bflg;
		logic [7:0]       mctl;
		logic             underflow_flag;
		logic [3:0]       pol;
		logic [3:0]       pol_seen;
		logic [15:0]      ld;
		logic [15:0]      mc;
		logic [3:0]       psc;
		logic [1:0]       rate;
		logic             pin;
		logic [15:0]      div;
		logic             tick;
		logic             latch;
		logic [3:0][7:0]  hold;
		logic [15:0]      rdata;
	} pamc_state_s;

	pamc_state_s s_q;
	pamc_state_s s_d;

	// last prescaler count before a down-counter tick
	function automatic logic [3:0] pamc_rate_last(input logic [1:0] code);
		case (code)
			2'h0: pamc_rate_last = 4'h0;
			2'h1: pamc_rate_last = 4'h3;
			2'h2: pamc_rate_last = 4'h7;
			default: pamc_rate_last = 4'hF;
		endcase
	endfunction

	logic       acc_any;
	logic       wr_any;
	logic [7:0] wb;
	logic       a_en;
	logic       b_en;
	logic       rise7;
	logic       fall7;
	logic       a_evt;
	logic       a_flag_evt;
	logic       a_inc;
	logic [16:0] a_sum;
	logic [16:0] b_sum;
	logic [8:0]  c_sum;
	logic       a_ovf;
	logic       b_ovf;
	logic       mc_tick;
	logic       mc_zero;
	logic       mc_load;
	logic       latch_mode;
	logic       latch_req;
	logic [1:0] ck_sel;
	logic       wr_ch;
	logic       wr_cl;
	logic [15:0] mc_wval;
	logic [15:0] mc_shown;

	always_comb begin
		s_d = s_q;
		s_d.latch = 1'b0;
		s_d.rdata = 16'h0000;
		acc_any = bus_wr || bus_rd;
		wr_any = bus_wr;
		wb = bus_wdata[7:0];
		a_en = s_q.actl[PAMC_A_EN];
		b_en = s_q.accum_b_system_enable;
		latch_mode = s_q.csys[PAMC_C_BUF] && s_q.csys[PAMC_C_LATCH_OR_QUEUE_SELECT];
		a_ovf = 1'b0;
		b_ovf = 1'b0;
		latch_req = 1'b0;
		mc_zero = 1'b0;
		mc_load = 1'b0;
		mc_tick = 1'b0;
		a_sum = 17'h00000;
		b_sum = 17'h00000;
		c_sum = 9'h000;
		mc_shown = s_q.mctl[PAMC_M_EN] ? s_q.mc : PAMC_MC_PRESET;

		// pin edges and the accumulator A count source
		s_d.pin = timer_pin_7;
		rise7 = timer_pin_7 && !s_q.pin;
		fall7 = !timer_pin_7 && s_q.pin;
		if (!s_q.actl[PAMC_A_MOD]) begin
			a_evt = s_q.actl[PAMC_A_EDGE] ? rise7 : fall7;
			a_flag_evt = a_evt;
		end else begin
			a_evt = timer_div64_tick && s_q.tsys[PAMC_T_EN]
				&& (timer_pin_7 != s_q.actl[PAMC_A_EDGE]);
			a_flag_evt = s_q.actl[PAMC_A_EDGE] ? rise7 : fall7;
		end
		a_inc = a_en && a_evt;

		// accumulator A: cascade or two independent byte counters
		if (a_en) begin
			if (a_inc) begin
				a_sum = {1'b0, s_q.cnt[3], s_q.cnt[2]} + 17'h00001;
				s_d.cnt[3] = a_sum[15:8];
				s_d.cnt[2] = a_sum[7:0];
				a_ovf = a_sum[16];
			end
		end else begin
			if (s_q.bcen[3] && chan_count_evt[3]) begin
				c_sum = {1'b0, s_q.cnt[3]} + 9'h001;
				s_d.cnt[3] = c_sum[7:0];
				a_ovf = c_sum[8];
			end
			if (s_q.bcen[2] && chan_count_evt[2])
				s_d.cnt[2] = s_q.cnt[2] + 8'h01;
		end

		// accumulator B on channel 0 events, or byte counters 1 and 0 on their own channels while B is off
		if (b_en) begin
			if (chan_count_evt[0]) begin
				b_sum = {1'b0, s_q.cnt[1], s_q.cnt[0]} + 17'h00001;
				s_d.cnt[1] = b_sum[15:8];
				s_d.cnt[0] = b_sum[7:0];
				b_ovf = b_sum[16];
			end
		end else begin
			if (s_q.bcen[1] && chan_count_evt[1])
				s_d.cnt[1] = s_q.cnt[1] + 8'h01;
			if (s_q.bcen[0] && chan_count_evt[0])
				s_d.cnt[0] = s_q.cnt[0] + 8'h01;
		end

		// timer counter clock; prescaler forced while A is off
		if (a_inc)
			s_d.div = s_q.div + 16'h0001;
		ck_sel = a_en ? s_q.actl[PAMC_A_CKH:PAMC_A_CKL] : PAMC_CK_PRESC;
		case (ck_sel)
			PAMC_CK_PRESC: s_d.tick = timer_presc_tick;
			PAMC_CK_ACC:   s_d.tick = a_inc;
			PAMC_CK_D256:  s_d.tick = a_inc && (s_q.div[7:0] == 8'hFF);
			default:       s_d.tick = a_inc && (s_q.div == 16'hFFFF);
		endcase

		// modulus down-counter
		if (!s_q.mctl[PAMC_M_EN]) begin
			s_d.mc = PAMC_MC_PRESET;
			s_d.psc = 4'h0;
		end else begin
			mc_tick = (s_q.psc == pamc_rate_last(s_q.rate));
			s_d.psc = mc_tick ? 4'h0 : s_q.psc + 4'h1;
			if (mc_tick) begin
				if (s_q.mc != 16'h0000) begin
					s_d.mc = s_q.mc - 16'h0001;
					mc_zero = (s_q.mc == 16'h0001);
				end else if (s_q.mctl[PAMC_M_MOD]) begin
					mc_load = 1'b1;
				end
			end
		end

		// register writes; a write wins over counting
		wr_ch = wr_any && (bus_addr == PAMC_ADR_MCNTH);
		wr_cl = wr_any && (bus_addr == PAMC_ADR_MCNTL) && !bus_word;
		mc_wval = s_q.ld;
		if (wr_ch && bus_word)
			mc_wval = bus_wdata;
		else if (wr_ch)
			mc_wval = {wb, s_q.ld[7:0]};
		else if (wr_cl)
			mc_wval = {s_q.ld[15:8], wb};
		if (wr_any) begin
			if (bus_addr == PAMC_ADR_ACTL) begin
				s_d.actl = wb & PAMC_ACTL_MASK;
			end else if (bus_addr == PAMC_ADR_AFLG) begin
				if (wb[PAMC_F_OV])
					s_d.aflg[PAMC_F_OV] = 1'b0;
				if (wb[PAMC_F_IE])
					s_d.aflg[PAMC_F_IE] = 1'b0;
			end else if (bus_addr == PAMC_ADR_CNT3) begin
				s_d.cnt[3] = bus_word ? bus_wdata[15:8] : wb;
				if (bus_word)
					s_d.cnt[2] = wb;
			end else if (bus_addr == PAMC_ADR_CNT2) begin
				s_d.cnt[2] = wb;
			end else if (bus_addr == PAMC_ADR_CNT1) begin
				s_d.cnt[1] = bus_word ? bus_wdata[15:8] : wb;
				if (bus_word)
					s_d.cnt[0] = wb;
			end else if (bus_addr == PAMC_ADR_CNT0) begin
				s_d.cnt[0] = wb;
			end else if (bus_addr == PAMC_ADR_MCTL) begin
				s_d.mctl = wb & PAMC_MCTL_MASK;
				if (wb[PAMC_M_LAT] && latch_mode)
					latch_req = 1'b1;
				if (wb[PAMC_M_FLD] && s_q.mctl[PAMC_M_EN])
					mc_load = 1'b1;
			end else if (bus_addr == PAMC_ADR_MFLG) begin
				if (wb[PAMC_M_ZF] && !s_q.tsys[PAMC_T_FFC])
					s_d.underflow_flag = 1'b0;
			end else if (bus_addr == PAMC_ADR_BCEN) begin
				s_d.bcen = wb[3:0];
			end else if (bus_addr == PAMC_ADR_CSYS) begin
				s_d.csys = wb[1:0];
			end else if (bus_addr == PAMC_ADR_TSYS) begin
				s_d.tsys = wb;
			end else if (bus_addr == PAMC_ADR_BCTL) begin
				s_d.accum_b_system_enable = wb[PAMC_B_EN];
			end else if (bus_addr == PAMC_ADR_BFLG) begin
				if (wb[PAMC_F_OV])
					s_d.bflg = 1'b0;
			end
		end

		// a count write sets the load register and reloads when enabled
		if (wr_ch || wr_cl) begin
			s_d.ld = mc_wval;
			if (s_q.mctl[PAMC_M_EN])
				mc_load = 1'b1;
			if (latch_mode && (mc_wval == 16'h0000))
				latch_req = 1'b1;
		end
		if (mc_load) begin
			s_d.mc = (wr_ch || wr_cl) ? mc_wval : s_q.ld;
			s_d.psc = 4'h0;
			s_d.rate = s_q.mctl[1:0];
		end

		// fast flag clear on count accesses
		if (acc_any && s_q.tsys[PAMC_T_FFC]) begin
			if (bus_addr == PAMC_ADR_CNT3 || bus_addr == PAMC_ADR_CNT2)
				s_d.aflg = 2'b00;
			if (bus_addr == PAMC_ADR_MCNTH || bus_addr == PAMC_ADR_MCNTL)
				s_d.underflow_flag = 1'b0;
		end

		// flag sets come last so an event beats a same-cycle clear
		if (a_ovf)
			s_d.aflg[PAMC_F_OV] = 1'b1;
		if (a_en && a_flag_evt)
			s_d.aflg[PAMC_F_IE] = 1'b1;
		if (b_ovf)
			s_d.bflg = 1'b1;
		if (mc_zero) begin
			s_d.underflow_flag = 1'b1;
			if (latch_mode)
				latch_req = 1'b1;
		end

		// latch into holding registers, then clear the byte counters
		if (latch_req) begin
			s_d.hold = s_q.cnt;
			s_d.cnt = {4{PAMC_RST_BYTE}};
			s_d.latch = 1'b1;
			s_d.pol_seen = 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (chan_capture[i] && !s_q.pol_seen[i]) begin
					s_d.pol[i] = chan_capture_rising[i];
					s_d.pol_seen[i] = 1'b1;
				end
			end
		end

		// read data, one cycle after the strobe
		if (bus_rd) begin
			if (bus_addr == PAMC_ADR_ACTL) begin
				s_d.rdata = {8'h00, s_q.actl};
			end else if (bus_addr == PAMC_ADR_AFLG) begin
				s_d.rdata = {14'h0000, s_q.aflg};
			end else if (bus_addr == PAMC_ADR_CNT3) begin
				s_d.rdata = bus_word ? {s_q.cnt[3], s_q.cnt[2]}
					: {8'h00, s_q.cnt[3]};
			end else if (bus_addr == PAMC_ADR_CNT2) begin
				s_d.rdata = {8'h00, s_q.cnt[2]};
			end else if (bus_addr == PAMC_ADR_CNT1) begin
				s_d.rdata = bus_word ? {s_q.cnt[1], s_q.cnt[0]}
					: {8'h00, s_q.cnt[1]};
			end else if (bus_addr == PAMC_ADR_CNT0) begin
				s_d.rdata = {8'h00, s_q.cnt[0]};
			end else if (bus_addr == PAMC_ADR_MCTL) begin
				s_d.rdata = {8'h00, s_q.mctl};
			end else if (bus_addr == PAMC_ADR_MFLG) begin
				s_d.rdata = {8'h00, s_q.underflow_flag, 3'h0, s_q.pol};
			end else if (bus_addr == PAMC_ADR_BCEN) begin
				s_d.rdata = {12'h000, s_q.bcen};
			end else if (bus_addr == PAMC_ADR_CSYS) begin
				s_d.rdata = {14'h0000, s_q.csys};
			end else if (bus_addr == PAMC_ADR_TSYS) begin
				s_d.rdata = {8'h00, s_q.tsys};
			end else if (bus_addr == PAMC_ADR_BCTL) begin
				s_d.rdata = {9'h000, s_q.accum_b_system_enable, 6'h00};
			end else if (bus_addr == PAMC_ADR_BFLG) begin
				s_d.rdata = {14'h0000, s_q.bflg, 1'b0};
			end else if (bus_addr == PAMC_ADR_MCNTH) begin
				s_d.rdata = s_q.mctl[PAMC_M_RDL] ? s_q.ld : mc_shown;
				if (!bus_word)
					s_d.rdata = {8'h00, s_d.rdata[15:8]};
			end else if (bus_addr == PAMC_ADR_MCNTL) begin
				s_d.rdata = {8'h00, s_q.mctl[PAMC_M_RDL] ? s_q.ld[7:0]
					: mc_shown[7:0]};
			end else begin
				s_d.rdata = 16'h0000;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.mc <= PAMC_MC_PRESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus_rdata = s_q.rdata;
	assign timer_count_tick = s_q.tick;
	assign capture_latch = s_q.latch;
	assign hold_accum = s_q.hold;
	assign accum_a_irq = (s_q.aflg[PAMC_F_OV] && s_q.actl[PAMC_A_OVI])
		|| (s_q.aflg[PAMC_F_IE] && s_q.actl[PAMC_A_II]);
	assign downcounter_irq = s_q.underflow_flag && s_q.mctl[PAMC_M_ZI];

endmodule
`default_nettype wire

// ==== bench/pamc_asserts.sv ====
// port checker for the accumulator and down-counter block
`timescale 1ns/1ns
`default_nettype none
module pamc_asserts
	import pamc_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic [7:0]  bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic        bus_word,
	input wire logic [15:0] bus_rdata,
	input wire logic        timer_pin_7,
	input wire logic        timer_presc_tick,
	input wire logic        timer_div64_tick,
	input wire logic [3:0]  chan_count_evt,
	input wire logic [3:0]  chan_capture,
	input wire logic [3:0]  chan_capture_rising,
	input wire logic        timer_count_tick,
	input wire logic        capture_latch,
	input wire logic [31:0] hold_accum,
	input wire logic        accum_a_irq,
	input wire logic        downcounter_irq
);
	logic [7:0] a_q;
	logic [7:0] m_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			a_q <= 8'h00;
			m_q <= 8'h00;
		end else if (bus_wr && bus_addr == PAMC_ADR_ACTL) begin
			a_q <= bus_wdata[7:0];
		end else if (bus_wr && bus_addr == PAMC_ADR_MCTL) begin
			m_q <= bus_wdata[7:0];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
		else $error("read data not idle");
	mctl_strobe_a: assert property ($past(bus_rd && bus_addr == PAMC_ADR_MCTL)
		|-> bus_rdata[4:3] == 2'h0) else $error("strobe bits read back");
	mflg_rsvd_a: assert property ($past(bus_rd && bus_addr == PAMC_ADR_MFLG)
		|-> bus_rdata[6:4] == 3'h0) else $error("flag reserved bits set");
	dc_irq_off_a: assert property (bus_wr && bus_addr == PAMC_ADR_MCTL
		&& !bus_wdata[7] |=> !downcounter_irq) else $error("down irq stays");
	a_irq_off_a: assert property (bus_wr && bus_addr == PAMC_ADR_ACTL
		&& bus_wdata[1:0] == 2'h0 |=> !accum_a_irq) else $error("acc irq stays");
	presc_clock_a: assert property (!$past(a_q[PAMC_A_EN])
		|-> timer_count_tick == $past(timer_presc_tick)) else $error("timer clock");
	dc_preset_a: assert property ($past(bus_rd && bus_word && m_q[2] == 1'b0
		&& m_q[5] == 1'b0 && bus_addr == PAMC_ADR_MCNTH) |-> bus_rdata == 16'hFFFF)
		else $error("idle count not preset");
	actl_read_a: assert property ($past(bus_rd && bus_addr == PAMC_ADR_ACTL)
		|-> bus_rdata == {8'h00, $past(a_q) & PAMC_ACTL_MASK}) else $error("ctl read");
	latch_c: cover property (capture_latch);
	dc_irq_c: cover property ($rose(downcounter_irq));
	a_irq_c: cover property ($rose(accum_a_irq));
	tick_c: cover property (timer_count_tick);
endmodule
bind pamc_core pamc_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
	.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_word(bus_word), .bus_rdata(bus_rdata),
	.timer_pin_7(timer_pin_7), .timer_presc_tick(timer_presc_tick),
	.timer_div64_tick(timer_div64_tick), .chan_count_evt(chan_count_evt),
	.chan_capture(chan_capture), .chan_capture_rising(chan_capture_rising),
	.timer_count_tick(timer_count_tick), .capture_latch(capture_latch),
	.hold_accum(hold_accum), .accum_a_irq(accum_a_irq),
	.downcounter_irq(downcounter_irq));
`default_nettype wire

// ==== bench/pamc_pin_model.sv ====
// input pin and timer prescaler ticks on the far side of the block
`timescale 1ns/1ns
`default_nettype none
module pamc_pin_model (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       go,
	input  wire logic [7:0] pulses,
	input  wire logic       gate,
	output var  logic       pin,
	output var  logic       presc,
	output var  logic       div64
);
	logic [8:0] left_q;
	logic [5:0] div_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			left_q <= 9'h000;
			div_q <= 6'h00;
		end else begin
			div_q <= div_q + 6'h01;
			if (go) begin
				left_q <= {pulses, 1'b0};
			end else if (left_q != 9'h000) begin
				left_q <= left_q - 9'h001;
			end
		end
	end
	// one-cycle low pulses, or held low while gate is set
	assign pin = !(left_q[0] || gate);
	assign presc = div_q[1:0] == 2'h3;
	assign div64 = div_q == 6'h3F;
endmodule
`default_nettype wire

// ==== bench/pamc_core_bench.sv ====
// self-checking bench for the accumulator and down-counter block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module pamc_core_bench
	import pamc_pkg::*;
;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  bus_addr = 8'h00;
	logic [15:0] bus_wdata = 16'h0000;
	logic        bus_wr = 1'b0;
	logic        bus_rd = 1'b0;
	logic        bus_word = 1'b0;
	logic [15:0] bus_rdata;
	logic        pin, presc, div64, tick, latch, a_irq, dc_irq;
	logic        go = 1'b0;
	logic        gate = 1'b0;
	logic        seen = 1'b0;
	logic [7:0]  npls = 8'h00;
	logic [3:0]  evt = 4'h0;
	logic [31:0] hold;
	logic [3:0]  cap = 4'h0;
	logic [3:0]  cap_rise = 4'h0;
	int          fails = 0;
	int          n_tests = 0;
	int          cycles = 0;
	int          nticks = 0;
	int          tick_base = 0;
	always #10 clk = ~clk;
	pamc_pin_model model (.clk(clk), .sys_rst(sys_rst), .go(go), .pulses(npls),
		.gate(gate), .pin(pin), .presc(presc), .div64(div64));
	pamc_core dut (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_word(bus_word), .bus_rdata(bus_rdata), .timer_pin_7(pin),
		.timer_presc_tick(presc), .timer_div64_tick(div64),
		.chan_count_evt(evt), .chan_capture(cap), .chan_capture_rising(cap_rise),
		.timer_count_tick(tick), .capture_latch(latch), .hold_accum(hold),
		.accum_a_irq(a_irq), .downcounter_irq(dc_irq));
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (latch === 1'b1) seen <= 1'b1;
		if (tick === 1'b1) nticks <= nticks + 1;
		if (cycles == 20000) begin
			fails++;
			conclude();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic w);
		bus_addr <= a;
		bus_wdata <= d;
		bus_word <= w;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic w, input logic [15:0] e);
		bus_addr <= a;
		bus_word <= w;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		@(negedge clk);
		`CHK($sformatf("reg %h", a), e, bus_rdata)
		@(posedge clk);
	endtask
	task automatic pls(input logic [7:0] n);
		npls <= n;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		cyc(2 * n + 4);
	endtask
	task automatic evp(input logic [3:0] m);
		evt <= m;
		@(posedge clk);
		evt <= 4'h0;
		@(posedge clk);
	endtask
	initial begin
		cyc(5);
		sys_rst <= 1'b0;
		@(posedge clk);
		for (int a = 160; a < 168; a++) rc(8'(a), 1'b0, 16'h0000);
		wr(PAMC_ADR_MCTL, 16'h0018, 1'b0);
		rc(PAMC_ADR_MCTL, 1'b0, 16'h0000);
		rc(8'hC0, 1'b0, 16'h0000);
		// event counting, falling then rising edges
		wr(PAMC_ADR_ACTL, 16'h0041, 1'b0);
		pls(8'h05);
		rc(PAMC_ADR_CNT3, 1'b1, 16'h0005);
		`CHK("acc irq", 1'b1, a_irq)
		wr(PAMC_ADR_AFLG, 16'h0001, 1'b0);
		`CHK("acc irq", 1'b0, a_irq)
		wr(PAMC_ADR_ACTL, 16'h0052, 1'b0);
		pls(8'h03);
		rc(PAMC_ADR_CNT3, 1'b1, 16'h0008);
		// wrap of the cascaded count
		wr(PAMC_ADR_CNT3, 16'hFFFE, 1'b1);
		wr(PAMC_ADR_AFLG, 16'h0003, 1'b0);
		pls(8'h02);
		rc(PAMC_ADR_CNT3, 1'b1, 16'h0000);
		`CHK("acc irq", 1'b1, a_irq)
		rc(PAMC_ADR_AFLG, 1'b0, 16'h0003);
		wr(PAMC_ADR_AFLG, 16'h0002, 1'b0);
		rc(PAMC_ADR_AFLG, 1'b0, 16'h0001);
		// fast clear by a count access
		wr(PAMC_ADR_TSYS, 16'h0090, 1'b0);
		rc(PAMC_ADR_CNT3, 1'b1, 16'h0000);
		rc(PAMC_ADR_AFLG, 1'b0, 16'h0000);
		// gated accumulation with pin low, timer on then off
		wr(PAMC_ADR_ACTL, 16'h0070, 1'b0);
		for (int t = 0; t < 2; t++) begin
			gate <= 1'b1;
			cyc(640);
			gate <= 1'b0;
			cyc(4);
			rc(PAMC_ADR_AFLG, 1'b0, 16'h0001);
			rc(PAMC_ADR_CNT3, 1'b1, 16'h000A);
			wr(PAMC_ADR_TSYS, 16'h0000, 1'b0);
		end
		// timer clock from the accumulator, then divided by 256
		wr(PAMC_ADR_ACTL, 16'h0044, 1'b0);
		cyc(2);
		tick_base = nticks;
		pls(8'h03);
		`CHK("acc clock ticks", tick_base + 3, nticks)
		wr(PAMC_ADR_ACTL, 16'h0048, 1'b0);
		cyc(2);
		tick_base = nticks;
		pls(8'hFF);
		pls(8'h01);
		`CHK("div256 ticks", tick_base + 1, nticks)
		// one-shot down count at rate 1
		rc(PAMC_ADR_MCNTH, 1'b1, 16'hFFFF);
		wr(PAMC_ADR_MCTL, 16'h0084, 1'b0);
		wr(PAMC_ADR_MCNTH, 16'h0005, 1'b1);
		cyc(8);
		rc(PAMC_ADR_MCNTH, 1'b1, 16'h0000);
		`CHK("down irq", 1'b1, dc_irq)
		rc(PAMC_ADR_MFLG, 1'b0, 16'h0080);
		wr(PAMC_ADR_MFLG, 16'h0080, 1'b0);
		`CHK("down irq", 1'b0, dc_irq)
		wr(PAMC_ADR_MCTL, 16'h00A4, 1'b0);
		rc(PAMC_ADR_MCNTH, 1'b1, 16'h0005);
		// modulus mode at rate 16 with a forced load
		wr(PAMC_ADR_MCTL, 16'h0000, 1'b0);
		wr(PAMC_ADR_MCTL, 16'h0047, 1'b0);
		wr(PAMC_ADR_MCNTH, 16'h0003, 1'b1);
		cyc(6);
		rc(PAMC_ADR_MCNTH, 1'b1, 16'h0003);
		cyc(15);
		rc(PAMC_ADR_MCNTH, 1'b1, 16'h0002);
		wr(PAMC_ADR_MCTL, 16'h004F, 1'b0);
		cyc(6);
		rc(PAMC_ADR_MCNTH, 1'b1, 16'h0003);
		cyc(60);
		rc(PAMC_ADR_MCNTH, 1'b1, 16'h0003);
		// independent byte counters, forced latch, then accumulator B
		wr(PAMC_ADR_MCTL, 16'h0000, 1'b0);
		wr(PAMC_ADR_ACTL, 16'h0000, 1'b0);
		wr(PAMC_ADR_CNT3, 16'h0000, 1'b1);
		wr(PAMC_ADR_BCEN, 16'h000F, 1'b0);
		wr(PAMC_ADR_CSYS, 16'h0003, 1'b0);
		repeat (3) evp(4'hF);
		rc(PAMC_ADR_CNT3, 1'b1, 16'h0303);
		wr(PAMC_ADR_MCTL, 16'h0010, 1'b0);
		cyc(3);
		`CHK("latch", 1'b1, seen)
		`CHK("hold", 32'h03030303, hold)
		rc(PAMC_ADR_CNT1, 1'b1, 16'h0000);
		// first capture polarity after the latch
		cap <= 4'h3;
		cap_rise <= 4'h1;
		@(posedge clk);
		cap_rise <= 4'h2;
		@(posedge clk);
		cap <= 4'h0;
		@(posedge clk);
		rc(PAMC_ADR_MFLG, 1'b0, 16'h0081);
		wr(PAMC_ADR_BCTL, 16'h0040, 1'b0);
		wr(PAMC_ADR_CNT1, 16'h00FF, 1'b1);
		evp(4'h1);
		rc(PAMC_ADR_CNT1, 1'b1, 16'h0100);
		wr(PAMC_ADR_CNT1, 16'hFFFF, 1'b1);
		evp(4'h1);
		rc(PAMC_ADR_BFLG, 1'b0, 16'h0002);
		// writing zero to the count latches in latch mode
		wr(PAMC_ADR_CNT1, 16'h1234, 1'b1);
		wr(PAMC_ADR_MCNTH, 16'h0000, 1'b1);
		`CHK("hold", 32'h00001234, hold)
		rc(PAMC_ADR_CNT1, 1'b1, 16'h0000);
		conclude();
	end
endmodule
`undef CHK
`default_nettype wire
